// *** hdl/async_chip_select_timing_config.sv ***
// Implementation choices: the strobed register port and the register addresses.
`timescale 1ns/100ps
// How it works
// - four region words; the selected region's word shapes every access
// - a word written before a request governs the next access
// - bit 31 clear: select held from setup through hold; set: select only in strobe
// - bit 30 set lets the synchronised wait input stretch the strobe
// - write setup lasts field 29:26 plus one cycles
// - write strobe lasts field 25:20 plus one cycles
// - write hold lasts field 19:17 plus one cycles
// - read setup lasts field 16:13 plus one cycles
// - read strobe lasts field 12:7 plus one cycles
// - read hold lasts field 6:4 plus one cycles
// - read/write turnaround gap of at least field 3:2 plus one cycles
// - field 1:0 picks 8-bit or 16-bit data; 2 and 3 act as 8-bit
module async_chip_select_timing_config #(
  parameter int ADDR_W = 24,
  parameter int NREGION = 4
) (
  input wire logic CLK, // 50 MHz system clock
  input wire logic SRST, // synchronous reset, high
  input wire logic [7:0] ADDR, // register byte address
  input wire logic [31:0] WDATA, // register write data
  input wire logic WR_STB, // register write strobe
  input wire logic RD_STB, // register read strobe
  output logic [31:0] RDATA, // register read data, cycle after strobe
  input wire logic ACC_REQ, // access request pulse
  input wire logic ACC_WRITE, // 1 write, 0 read
  input wire logic [1:0] ACC_REGION, // 0..3 = regions two..five
  input wire logic [ADDR_W-1:0] ACC_ADDR, // access address
  input wire logic [15:0] ACC_WDATA, // write data
  output logic ACC_BUSY, // access in progress
  output logic ACC_DONE, // one-cycle completion pulse
  output logic [15:0] ACC_RDATA, // read result
  output logic [3:0] MEM_CS_N, // chip selects, low active
  output logic MEM_WE_N, // write strobe, low active
  output logic MEM_OE_N, // read strobe, low active
  output logic [ADDR_W-1:0] MEM_ADDR, // memory address
  output logic [15:0] MEM_DOUT, // data pin output
  output logic MEM_DOE, // data pin enable, high drives
  input wire logic [15:0] MEM_DIN, // data pin input
  input wire logic MEM_WAIT, // wait pin, high stalls
  output logic MEM_WIDE // 1 when region bus is 16 bits
);
  typedef struct packed {
    async_cfg_pkg::eng_st_t st;
    logic [5:0] cnt;
    logic [6:0] plen;
    logic [31:0] cfg;
    logic write;
    logic [1:0] region;
    logic [ADDR_W-1:0] addr;
    logic [15:0] wdata;
    logic dirv;
    logic lastw;
    logic [15:0] din_s1;
    logic [15:0] din_s2;
    logic wait_s1;
    logic wait_s2;
    logic busy;
    logic done;
    logic [15:0] rdata;
    logic [3:0] cs_n;
    logic we_n;
    logic oe_n;
    logic [15:0] dout;
    logic doe;
    logic wide;
  } eng_t;

  eng_t s_r, s_nxt;
  logic [31:0] cfg_b_data;
  logic cfg_wr;
  logic cfg_hit;
  logic sts_hit;
  logic [31:0] sts_word;
  logic [1:0] rd_b_idx;

  if (NREGION != async_cfg_pkg::NREG || ADDR_W < 1 || ADDR_W > 32) begin : g_chk
    $error("four regions and an address width of 1..32 are supported");
  end

  // phase length field for a direction, zero-extended
  function automatic logic [5:0] flen(input logic [31:0] c, input logic w,
                                      input async_cfg_pkg::eng_st_t p);
    logic [5:0] v;
    v = 6'h00;
    if (p == async_cfg_pkg::ST_SETUP) begin
      v = {2'h0, w ? c[async_cfg_pkg::WSU_LSB +: async_cfg_pkg::SU_W]
                   : c[async_cfg_pkg::RSU_LSB +: async_cfg_pkg::SU_W]};
    end else if (p == async_cfg_pkg::ST_STROBE) begin
      v = w ? c[async_cfg_pkg::WST_LSB +: async_cfg_pkg::STB_W]
            : c[async_cfg_pkg::RST_LSB +: async_cfg_pkg::STB_W];
    end else if (p == async_cfg_pkg::ST_HOLD) begin
      v = {3'h0, w ? c[async_cfg_pkg::WHO_LSB +: async_cfg_pkg::HO_W]
                   : c[async_cfg_pkg::RHO_LSB +: async_cfg_pkg::HO_W]};
    end else if (p == async_cfg_pkg::ST_TURN) begin
      v = {4'h0, c[async_cfg_pkg::TURN_LSB +: async_cfg_pkg::TURN_W]};
    end
    return v;
  endfunction : flen

  // register decode; unmapped addresses read zero, writes ignored
  assign cfg_hit = (ADDR >= async_cfg_pkg::OFS_CFG_BASE) && (ADDR <= async_cfg_pkg::OFS_CFG_LAST)
                   && (ADDR[1:0] == 2'h0);
  assign sts_hit = (ADDR == async_cfg_pkg::OFS_STATUS);
  assign cfg_wr = WR_STB && cfg_hit;
  assign sts_word = {29'h0, s_r.dirv, s_r.lastw, s_r.busy};
  // engine reads the requested region's word while still idle
  assign rd_b_idx = (s_r.st == async_cfg_pkg::ST_IDLE) ? ACC_REGION : s_r.region;

  // one word per region; the bus answer comes out of its register
  cfg_store #(
    .DEPTH(async_cfg_pkg::NREG),
    .WIDTH(32),
    .INIT(async_cfg_pkg::CFG_RESET)
  ) u_store (
    .clk(CLK),
    .srst(SRST),
    .wr_en(cfg_wr),
    .wr_idx(ADDR[3:2]),
    .wr_data(WDATA),
    .rd_a_en(RD_STB),
    .rd_a_idx(ADDR[3:2]),
    .rd_a_alt_sel(!cfg_hit),
    .rd_a_alt(sts_hit ? sts_word : 32'h0000_0000),
    .rd_a_data(RDATA),
    .rd_b_idx(rd_b_idx),
    .rd_b_data(cfg_b_data)
  );

  // access engine and pin shaping
  always_comb begin
    s_nxt = s_r;
    s_nxt.din_s1 = MEM_DIN;
    s_nxt.din_s2 = s_r.din_s1;
    s_nxt.wait_s1 = MEM_WAIT;
    s_nxt.wait_s2 = s_r.wait_s1;
    s_nxt.done = 1'b0;
    unique case (s_r.st)
      async_cfg_pkg::ST_IDLE: begin
        if (ACC_REQ) begin
          s_nxt.write = ACC_WRITE;
          s_nxt.region = ACC_REGION;
          s_nxt.addr = ACC_ADDR;
          s_nxt.wdata = ACC_WDATA;
          s_nxt.st = async_cfg_pkg::ST_LOAD;
        end
      end
      async_cfg_pkg::ST_LOAD: begin
        // word is latched per access, so a later write never tears one
        s_nxt.cfg = cfg_b_data;
        if (s_r.dirv && (s_r.lastw != s_r.write)) begin
          s_nxt.st = async_cfg_pkg::ST_TURN;
          s_nxt.cnt = flen(cfg_b_data, s_r.write, async_cfg_pkg::ST_TURN);
        end else begin
          s_nxt.st = async_cfg_pkg::ST_SETUP;
          s_nxt.cnt = flen(cfg_b_data, s_r.write, async_cfg_pkg::ST_SETUP);
        end
      end
      async_cfg_pkg::ST_TURN: begin
        if (s_r.cnt == 6'h00) begin
          s_nxt.st = async_cfg_pkg::ST_SETUP;
          s_nxt.cnt = flen(s_r.cfg, s_r.write, async_cfg_pkg::ST_SETUP);
        end else begin
          s_nxt.cnt = s_r.cnt - 6'h01;
        end
      end
      async_cfg_pkg::ST_SETUP: begin
        if (s_r.cnt == 6'h00) begin
          s_nxt.st = async_cfg_pkg::ST_STROBE;
          s_nxt.cnt = flen(s_r.cfg, s_r.write, async_cfg_pkg::ST_STROBE);
        end else begin
          s_nxt.cnt = s_r.cnt - 6'h01;
        end
      end
      async_cfg_pkg::ST_STROBE: begin
        if (s_r.cnt != 6'h00) begin
          s_nxt.cnt = s_r.cnt - 6'h01;
        end else if (!(s_r.cfg[async_cfg_pkg::EXT_WAIT_BIT] && s_r.wait_s2)) begin
          s_nxt.st = async_cfg_pkg::ST_HOLD;
          s_nxt.cnt = flen(s_r.cfg, s_r.write, async_cfg_pkg::ST_HOLD);
        end
      end
      async_cfg_pkg::ST_HOLD: begin
        if (s_r.cnt == 6'h00) begin
          s_nxt.st = async_cfg_pkg::ST_IDLE;
          s_nxt.done = 1'b1;
          s_nxt.dirv = 1'b1;
          s_nxt.lastw = s_r.write;
          if (!s_r.write) begin
            // synchroniser delay: value seen on the pins two cycles earlier
            s_nxt.rdata = (s_r.cfg[async_cfg_pkg::ASZ_LSB +: async_cfg_pkg::ASZ_W]
                           == async_cfg_pkg::ASZ_16) ? s_r.din_s2
                                                     : {8'h00, s_r.din_s2[7:0]};
          end
        end else begin
          s_nxt.cnt = s_r.cnt - 6'h01;
        end
      end
    endcase
    // phase length counter, zero on the first cycle of each phase
    s_nxt.plen = (s_nxt.st != s_r.st) ? 7'h00 : s_r.plen + 7'h01;
    // pins follow the next state so they come straight off flops
    s_nxt.busy = (s_nxt.st != async_cfg_pkg::ST_IDLE);
    s_nxt.cs_n = 4'hF;
    s_nxt.we_n = 1'b1;
    s_nxt.oe_n = 1'b1;
    s_nxt.doe = 1'b0;
    s_nxt.wide = (s_nxt.cfg[async_cfg_pkg::ASZ_LSB +: async_cfg_pkg::ASZ_W]
                  == async_cfg_pkg::ASZ_16);
    s_nxt.dout = s_nxt.wide ? s_nxt.wdata : {8'h00, s_nxt.wdata[7:0]};
    if (s_nxt.st == async_cfg_pkg::ST_SETUP || s_nxt.st == async_cfg_pkg::ST_STROBE
        || s_nxt.st == async_cfg_pkg::ST_HOLD) begin
      s_nxt.doe = s_nxt.write;
      if (!s_nxt.cfg[async_cfg_pkg::SS_BIT] || s_nxt.st == async_cfg_pkg::ST_STROBE) begin
        s_nxt.cs_n[s_nxt.region] = 1'b0;
      end
    end
    if (s_nxt.st == async_cfg_pkg::ST_STROBE) begin
      s_nxt.we_n = !s_nxt.write;
      s_nxt.oe_n = s_nxt.write;
    end
  end

  always_ff @(posedge CLK) begin
    if (SRST) begin
      s_r <= '{st: async_cfg_pkg::ST_IDLE, cfg: async_cfg_pkg::CFG_RESET,
               cs_n: 4'hF, we_n: 1'b1, oe_n: 1'b1, default: '0};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign ACC_BUSY = s_r.busy;
  assign ACC_DONE = s_r.done;
  assign ACC_RDATA = s_r.rdata;
  assign MEM_CS_N = s_r.cs_n;
  assign MEM_WE_N = s_r.we_n;
  assign MEM_OE_N = s_r.oe_n;
  assign MEM_ADDR = s_r.addr;
  assign MEM_DOUT = s_r.dout;
  assign MEM_DOE = s_r.doe;
  assign MEM_WIDE = s_r.wide;

  // checks on phase timing and pin shaping
  default clocking cb @(posedge CLK); endclocking
  default disable iff (SRST);

  a_wsetup_len: assert property (
    (s_r.st == async_cfg_pkg::ST_SETUP && s_nxt.st != async_cfg_pkg::ST_SETUP && s_r.write)
    |-> s_r.plen == {1'b0, flen(s_r.cfg, 1'b1, async_cfg_pkg::ST_SETUP)})
    else $error("write setup length wrong");
  a_wstrobe_len: assert property (
    (s_r.st == async_cfg_pkg::ST_STROBE && s_nxt.st == async_cfg_pkg::ST_HOLD && s_r.write
     && !s_r.cfg[async_cfg_pkg::EXT_WAIT_BIT])
    |-> s_r.plen == {1'b0, flen(s_r.cfg, 1'b1, async_cfg_pkg::ST_STROBE)})
    else $error("write strobe length wrong");
  a_whold_len: assert property (
    (s_r.st == async_cfg_pkg::ST_HOLD && s_r.write) ##1 (s_r.st != async_cfg_pkg::ST_HOLD)
    |-> $past(s_r.plen) == {1'b0, flen(s_r.cfg, 1'b1, async_cfg_pkg::ST_HOLD)} && ACC_DONE)
    else $error("write hold length wrong");
  a_rsetup_len: assert property (
    (s_r.st == async_cfg_pkg::ST_SETUP && s_nxt.st != async_cfg_pkg::ST_SETUP && !s_r.write)
    |-> s_r.plen == {1'b0, flen(s_r.cfg, 1'b0, async_cfg_pkg::ST_SETUP)})
    else $error("read setup length wrong");
  a_rstrobe_len: assert property (
    (s_r.st == async_cfg_pkg::ST_STROBE && s_nxt.st == async_cfg_pkg::ST_HOLD && !s_r.write
     && !s_r.cfg[async_cfg_pkg::EXT_WAIT_BIT])
    |-> s_r.plen == {1'b0, flen(s_r.cfg, 1'b0, async_cfg_pkg::ST_STROBE)})
    else $error("read strobe length wrong");
  a_rhold_len: assert property (
    (s_r.st == async_cfg_pkg::ST_HOLD && s_nxt.st == async_cfg_pkg::ST_IDLE && !s_r.write)
    |-> s_r.plen == {1'b0, flen(s_r.cfg, 1'b0, async_cfg_pkg::ST_HOLD)})
    else $error("read hold length wrong");
  a_turn_len: assert property (
    (s_r.st == async_cfg_pkg::ST_TURN && s_nxt.st == async_cfg_pkg::ST_SETUP)
    |-> s_r.plen == {1'b0, flen(s_r.cfg, 1'b0, async_cfg_pkg::ST_TURN)})
    else $error("turnaround length wrong");
  a_same_dir: assert property (
    (s_r.st == async_cfg_pkg::ST_LOAD && (!s_r.dirv || s_r.lastw == s_r.write))
    |=> s_r.st == async_cfg_pkg::ST_SETUP)
    else $error("turnaround inserted without direction change");
  a_strobe_only: assert property (
    (!MEM_WE_N || !MEM_OE_N) |-> s_r.st == async_cfg_pkg::ST_STROBE
    && $past(s_r.st) inside {async_cfg_pkg::ST_SETUP, async_cfg_pkg::ST_STROBE})
    else $error("strobe outside strobe phase");
  a_sel_strobe: assert property (
    (s_r.st == async_cfg_pkg::ST_SETUP)
    |-> (MEM_CS_N == 4'hF) == s_r.cfg[async_cfg_pkg::SS_BIT])
    else $error("select shaping does not follow mode bit");
  a_region_cs: assert property (
    (s_r.st == async_cfg_pkg::ST_STROBE) |-> MEM_CS_N == ~(4'h1 << s_r.region))
    else $error("wrong chip select in strobe");
  a_wait_extend: assert property (
    (s_r.st == async_cfg_pkg::ST_STROBE && s_r.cnt == 6'h00 && s_r.wait_s2
     && s_r.cfg[async_cfg_pkg::EXT_WAIT_BIT]) |=> s_r.st == async_cfg_pkg::ST_STROBE)
    else $error("wait did not stretch strobe");
  a_byte_lane: assert property (
    (MEM_DOE && !MEM_WIDE) |-> MEM_DOUT[15:8] == 8'h00)
    else $error("upper byte driven on 8-bit region");
endmodule : async_chip_select_timing_config

// *** hdl/async_cfg_pkg.sv ***
package async_cfg_pkg;
  // register map, byte addresses on the plain register port
  localparam int NREG = 4;
  localparam logic [7:0] OFS_CFG_BASE = 8'h00; // region words at 00,04,08,0C
  localparam logic [7:0] OFS_CFG_LAST = 8'h0C;
  localparam logic [7:0] OFS_STATUS = 8'h10;
  // configuration word layout
  localparam int SS_BIT = 31;
  localparam int EXT_WAIT_BIT = 30;
  localparam int WSU_LSB = 26;
  localparam int WST_LSB = 20;
  localparam int WHO_LSB = 17;
  localparam int RSU_LSB = 13;
  localparam int RST_LSB = 7;
  localparam int RHO_LSB = 4;
  localparam int TURN_LSB = 2;
  localparam int ASZ_LSB = 0;
  localparam int SU_W = 4;
  localparam int STB_W = 6;
  localparam int HO_W = 3;
  localparam int TURN_W = 2;
  localparam int ASZ_W = 2;
  localparam logic [31:0] CFG_RESET = 32'h3FFFFFFC;
  localparam logic [1:0] ASZ_8 = 2'h0;
  localparam logic [1:0] ASZ_16 = 2'h1;
  // status word layout
  localparam int STS_BUSY_BIT = 0;
  localparam int STS_LASTW_BIT = 1;
  localparam int STS_DIRV_BIT = 2;
  // access engine states
  typedef enum logic [2:0] {ST_IDLE, ST_LOAD, ST_TURN, ST_SETUP, ST_STROBE, ST_HOLD} eng_st_t;
endpackage : async_cfg_pkg

// *** hdl/cfg_store.sv ***
`timescale 1ns/100ps
module cfg_store #(
  parameter int DEPTH = 4,
  parameter int WIDTH = 32,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  input wire logic clk, // system clock
  input wire logic srst, // synchronous reset, high
  input wire logic wr_en, // write strobe
  input wire logic [$clog2(DEPTH)-1:0] wr_idx, // write word index
  input wire logic [WIDTH-1:0] wr_data, // write data
  input wire logic rd_a_en, // bus read strobe
  input wire logic [$clog2(DEPTH)-1:0] rd_a_idx, // bus read index
  input wire logic rd_a_alt_sel, // return alt word instead
  input wire logic [WIDTH-1:0] rd_a_alt, // status or zero word
  output logic [WIDTH-1:0] rd_a_data, // bus read data, registered
  input wire logic [$clog2(DEPTH)-1:0] rd_b_idx, // engine read index
  output logic [WIDTH-1:0] rd_b_data // engine read data, registered
);
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [WIDTH-1:0] rd_a;
    logic [WIDTH-1:0] rd_b;
  } store_t;

  store_t s_r, s_nxt;

  if (DEPTH < 2) begin : g_chk
    $error("cfg_store needs at least two words");
  end

  // read ports see the old word on a same-cycle write
  always_comb begin
    s_nxt = s_r;
    if (wr_en) begin
      s_nxt.mem[wr_idx] = wr_data;
    end
    if (rd_a_en) begin
      s_nxt.rd_a = rd_a_alt_sel ? rd_a_alt : s_r.mem[rd_a_idx];
    end
    s_nxt.rd_b = s_r.mem[rd_b_idx];
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      s_r <= '{mem: {DEPTH{INIT}}, rd_a: '0, rd_b: INIT};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign rd_a_data = s_r.rd_a;
  assign rd_b_data = s_r.rd_b;
endmodule : cfg_store

// *** testbench/async_mem_model.sv ***
`timescale 1ns/100ps
module async_mem_model (
  input wire logic clk, // system clock
  input wire logic [3:0] cs_n, // region selects, low active
  input wire logic oe_n, // read strobe, low active
  input wire logic we_n, // write strobe, low active
  input wire logic doe, // block drives data
  input wire logic [23:0] addr, // address pins
  input wire logic [15:0] dout, // data from block
  input wire logic [7:0] stall_len, // strobe cycles to hold wait high
  output logic [15:0] din, // data toward block
  output logic stall // wait pin, high stalls
);
  logic [15:0] mem [16];
  logic [15:0] idle_r = 16'h0000;
  logic [7:0] stb_cnt_r = 8'h00;
  logic drive;
  // drive the word while selected and the block is not driving, hold included:
  // the block samples through a two-flop synchroniser; released bus flips each cycle
  assign drive = (cs_n != 4'hF) && !doe;
  assign din = drive ? mem[addr[3:0]] : idle_r;
  // wait rises with the strobe and drops after stall_len strobe cycles
  assign stall = !(oe_n && we_n) && (stb_cnt_r < stall_len);
  // storage takes data while strobe and select are low
  always @(posedge clk) begin
    idle_r <= ~din;
    stb_cnt_r <= (oe_n && we_n) ? 8'h00 : stb_cnt_r + 8'h01;
    if (!we_n && doe && cs_n != 4'hF) begin
      mem[addr[3:0]] <= dout;
    end
  end
endmodule : async_mem_model

// *** testbench/async_chip_select_timing_config_test.sv ***
`timescale 1ns/100ps
module async_chip_select_timing_config_test;
  logic CLK = 1'b0;
  logic SRST = 1'b1;
  logic [7:0] ADDR = 8'h00;
  logic [31:0] WDATA = 32'h00000000;
  logic WR_STB = 1'b0;
  logic RD_STB = 1'b0;
  logic ACC_REQ = 1'b0;
  logic ACC_WRITE = 1'b0;
  logic [1:0] ACC_REGION = 2'h0;
  logic [23:0] ACC_ADDR = 24'h000000;
  logic [15:0] ACC_WDATA = 16'h0000;
  logic [7:0] stall_len = 8'h00;
  logic [31:0] RDATA;
  logic ACC_BUSY, ACC_DONE, MEM_WE_N, MEM_OE_N, MEM_DOE, MEM_WAIT, MEM_WIDE;
  logic [15:0] ACC_RDATA, MEM_DOUT, MEM_DIN;
  logic [3:0] MEM_CS_N;
  logic [23:0] MEM_ADDR;
  logic [31:0] cfgw [4];
  logic seen_stb = 1'b0;
  logic has_prev = 1'b0;
  logic last_wr = 1'b0;
  int fails = 0;
  int checks = 0;
  int su_c, stb_c, ho_c, bad_c;

  async_chip_select_timing_config uut (.CLK(CLK), .SRST(SRST), .ADDR(ADDR), .WDATA(WDATA),
    .WR_STB(WR_STB), .RD_STB(RD_STB), .RDATA(RDATA), .ACC_REQ(ACC_REQ),
    .ACC_WRITE(ACC_WRITE), .ACC_REGION(ACC_REGION), .ACC_ADDR(ACC_ADDR),
    .ACC_WDATA(ACC_WDATA), .ACC_BUSY(ACC_BUSY), .ACC_DONE(ACC_DONE), .ACC_RDATA(ACC_RDATA),
    .MEM_CS_N(MEM_CS_N), .MEM_WE_N(MEM_WE_N), .MEM_OE_N(MEM_OE_N), .MEM_ADDR(MEM_ADDR),
    .MEM_DOUT(MEM_DOUT), .MEM_DOE(MEM_DOE), .MEM_DIN(MEM_DIN), .MEM_WAIT(MEM_WAIT),
    .MEM_WIDE(MEM_WIDE));

  async_mem_model mem_dev (.clk(CLK), .cs_n(MEM_CS_N), .oe_n(MEM_OE_N), .we_n(MEM_WE_N),
    .doe(MEM_DOE), .addr(MEM_ADDR), .dout(MEM_DOUT), .stall_len(stall_len),
    .din(MEM_DIN), .stall(MEM_WAIT));

  // 50 MHz clock
  initial begin
    forever #10 CLK = ~CLK;
  end

  // phase counters from the pins; select cycles outside the strobe split by side
  always @(posedge CLK) begin
    if (MEM_WE_N === 1'b0 || MEM_OE_N === 1'b0) begin
      stb_c++;
      seen_stb = 1'b1;
    end else if (MEM_CS_N[ACC_REGION] === 1'b0) begin
      ho_c += seen_stb;
      su_c += !seen_stb;
    end
    if ((MEM_CS_N | (4'h1 << ACC_REGION)) !== 4'hF) bad_c++;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("FAIL at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge CLK);
    ADDR <= a;
    WDATA <= d;
    WR_STB <= 1'b1;
    @(posedge CLK);
    WR_STB <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge CLK);
    ADDR <= a;
    RD_STB <= 1'b1;
    @(posedge CLK);
    RD_STB <= 1'b0;
    #1;
    chk(RDATA, exp);
  endtask : rd

  function automatic logic [31:0] cfg(input logic ss, xw, input logic [3:0] wsu,
    input logic [5:0] wst, input logic [2:0] who, input logic [3:0] rsu,
    input logic [5:0] rst, input logic [2:0] rho, input logic [1:0] trn, asz);
    return {ss, xw, wsu, wst, who, rsu, rst, rho, trn, asz};
  endfunction : cfg

  // one access; timing expected from the tb copy of the region word
  task automatic acc(input logic [1:0] r, input logic w, input logic [3:0] a,
    input logic [15:0] d, input logic exw);
    logic [31:0] c;
    int su, st, ho, lat, turn, ext, bsy;
    c = cfgw[r];
    su = w ? c[29:26] : c[16:13];
    st = w ? c[25:20] : c[12:7];
    ho = w ? c[19:17] : c[6:4];
    turn = (has_prev && last_wr != w) ? c[3:2] + 1 : 0;
    @(posedge CLK);
    su_c = 0;
    stb_c = 0;
    ho_c = 0;
    bad_c = 0;
    seen_stb = 1'b0;
    ACC_REQ <= 1'b1;
    ACC_WRITE <= w;
    ACC_REGION <= r;
    ACC_ADDR <= {20'h00000, a};
    ACC_WDATA <= d;
    @(posedge CLK);
    ACC_REQ <= 1'b0;
    lat = 0;
    bsy = 0;
    do begin
      @(posedge CLK);
      #1;
      lat++;
      if (ACC_BUSY === 1'b1) bsy++;
    end while (ACC_DONE !== 1'b1 && lat < 300);
    // wait seen two cycles late through the synchroniser, so strobe ends stall_len + 2 in
    ext = exw ? int'(stall_len) + 2 - st : 0;
    if (exw) chk(stb_c > st + 1, 1);
    chk(lat, turn + su + st + ho + ext + 4);
    chk(bsy, turn + su + st + ho + ext + 3);
    chk(stb_c, st + 1 + ext);
    chk(su_c, c[31] ? 0 : su + 1);
    chk(ho_c, c[31] ? 0 : ho + 1);
    chk(bad_c, 0);
    chk(MEM_WIDE, c[1:0] == 2'h1);
    if (!w) chk(ACC_RDATA, c[1:0] == 2'h1 ? d : {8'h00, d[7:0]});
    has_prev = 1'b1;
    last_wr = w;
  endtask : acc

  task automatic finish_test();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : finish_test

  // the sequence needs under two hundred cycles; ten thousand means a hang
  initial begin
    #200000;
    fails++;
    finish_test();
  end

  // main sequence; only region five enables wait, the rest keep bit 30 clear
  initial begin
    repeat (10) @(posedge CLK);
    SRST <= 1'b0;
    #1;
    chk(MEM_CS_N, 4'hF);
    for (int i = 0; i < 4; i++) rd(8'(4 * i), 32'h3FFFFFFC);
    rd(8'h20, 32'h00000000);
    wr(8'h10, 32'hFFFFFFFF);
    rd(8'h10, 32'h00000000);
    cfgw[0] = cfg(1'b0, 1'b0, 4'h2, 6'h03, 3'h1, 4'h1, 6'h02, 3'h1, 2'h1, 2'h1);
    cfgw[1] = cfg(1'b0, 1'b0, 4'h0, 6'h00, 3'h0, 4'h3, 6'h05, 3'h2, 2'h3, 2'h1);
    cfgw[2] = cfg(1'b1, 1'b0, 4'h1, 6'h02, 3'h0, 4'h1, 6'h02, 3'h1, 2'h0, 2'h1);
    cfgw[3] = cfg(1'b0, 1'b1, 4'h0, 6'h01, 3'h0, 4'h0, 6'h02, 3'h1, 2'h2, 2'h0);
    for (int i = 0; i < 4; i++) wr(8'(4 * i), cfgw[i]);
    for (int i = 0; i < 4; i++) rd(8'(4 * i), cfgw[i]);
    acc(2'h0, 1'b1, 4'h3, 16'hBEEF, 1'b0);
    acc(2'h0, 1'b0, 4'h3, 16'hBEEF, 1'b0);
    acc(2'h1, 1'b0, 4'h3, 16'hBEEF, 1'b0);
    acc(2'h2, 1'b1, 4'h5, 16'h1234, 1'b0);
    acc(2'h2, 1'b0, 4'h5, 16'h1234, 1'b0);
    acc(2'h3, 1'b1, 4'h6, 16'hA55A, 1'b0);
    @(posedge CLK);
    stall_len <= 8'h05;
    acc(2'h3, 1'b0, 4'h6, 16'hA55A, 1'b1);
    cfgw[0][12:7] = 6'h04;
    wr(8'h00, cfgw[0]);
    acc(2'h0, 1'b0, 4'h6, 16'h005A, 1'b0);
    rd(8'h10, 32'h00000004);
    finish_test();
  end
endmodule : async_chip_select_timing_config_test
